/* rtl/crf_core.v */
`timescale 1ns/1ps
`include "crf_consts.vh"

// Operation
// [RULE1] 16-bit program counter, incremented just before every fetch.
// [RULE2] Increment wraps within low 12 bits, no carry into top 4.
// [RULE3] Top 4 bits reset to zero; changed only by pointer exchange. The core also changes them on a register port write to the PC.
// [RULE4] Three 16-bit pointers, loadable by program, general purpose.
// [RULE5] Interrupt swaps pointer 3 into PC; software preloads address minus one.
// [RULE6] 8-bit accumulator takes results, shifts, rotates and exchanges.
// [RULE7] Indexed displacement of -128 is replaced by extension register.
// [RULE8] Opcode captured in hidden instruction register on each fetch.
// [RULE9] Hidden data register captures and holds bus bytes during strobes.
// [RULE10] ALU does OR, XOR, increment, decrement, binary and BCD add.
// [RULE11] Right shifts with/without link or serial in, rotates with/without link.
// [RULE12] Low or high pointer byte swaps with accumulator.
// [RULE13] Whole PC swaps with any pointer in one operation.
// [RULE14] Accumulator loads from or swaps with extension register.
// [RULE15] Status copy into accumulator leaves status unchanged.
// [RULE16] Accumulator copy into status skips bits 4 and 5.
// [RULE17] Flags 0 to 2 drive latched output pins.
// [RULE18] Interrupt enable changes only by program; clear blocks requests. The core also clears it on interrupt service entry.
// [RULE19] With enable set, high first sense input requests interrupt.
// [RULE20] Second sense input is status only, never an interrupt.
// [RULE21] Overflow set by binary and complement adds, untouched by BCD add.
// [RULE22] Carry/link from bit 7 in adds; feeds adds, link shifts, rotates.
// [RULE23] Reset clears every visible register so first fetch is address one.
// [RULE24] Status bits 4 and 5 show live sense pin levels on read.
module crf_core (
  ref_clk,
  resetn,
  opCode,
  opPtrSel,
  opData,
  busDataIn,
  readStrobeN,
  writeStrobeN,
  serialIn,
  irqSenseIn,
  auxSenseIn,
  regAddr,
  regWrData,
  regWr,
  regRd,
  regRdData,
  busDataOut,
  busDataOe,
  effAddr,
  fetchAddr,
  instrCode,
  serialOut,
  userOut,
  irqRequest
);
  input wire ref_clk;
  input wire resetn;
  input wire [4:0] opCode;
  input wire [1:0] opPtrSel;
  input wire [7:0] opData;
  input wire [7:0] busDataIn;
  input wire readStrobeN;
  input wire writeStrobeN;
  input wire serialIn;
  input wire irqSenseIn;
  input wire auxSenseIn;
  input wire [3:0] regAddr;
  input wire [15:0] regWrData;
  input wire regWr;
  input wire regRd;
  output reg [15:0] regRdData;
  output wire [7:0] busDataOut;
  output wire busDataOe;
  output reg [15:0] effAddr;
  output wire [15:0] fetchAddr;
  output wire [7:0] instrCode;
  output wire serialOut;
  output wire [2:0] userOut;
  output wire irqRequest;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, a change counts when stages 2 and 3 agree
  reg [2:0] saSync_r;
  reg [2:0] sbSync_r;
  reg [2:0] rdSync_r;
  reg [2:0] wrSync_r;
  reg [2:0] siSync_r;
  reg saLvl_r;
  reg sbLvl_r;
  reg rdLvl_r;
  reg wrLvl_r;
  reg siLvl_r;
  reg [7:0] busIn1_r;
  reg [7:0] busIn2_r;

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      saSync_r <= 3'h0;
      sbSync_r <= 3'h0;
      rdSync_r <= 3'h7;
      wrSync_r <= 3'h7;
      siSync_r <= 3'h0;
      saLvl_r <= 1'b0;
      sbLvl_r <= 1'b0;
      rdLvl_r <= 1'b1;
      wrLvl_r <= 1'b1;
      siLvl_r <= 1'b0;
      busIn1_r <= 8'h00;
      busIn2_r <= 8'h00;
    end else begin
      saSync_r <= {saSync_r[1:0], irqSenseIn};
      sbSync_r <= {sbSync_r[1:0], auxSenseIn};
      rdSync_r <= {rdSync_r[1:0], readStrobeN};
      wrSync_r <= {wrSync_r[1:0], writeStrobeN};
      siSync_r <= {siSync_r[1:0], serialIn};
      busIn1_r <= busDataIn;
      busIn2_r <= busIn1_r;
      if (saSync_r[1] == saSync_r[2]) saLvl_r <= saSync_r[2];
      if (sbSync_r[1] == sbSync_r[2]) sbLvl_r <= sbSync_r[2];
      if (rdSync_r[1] == rdSync_r[2]) rdLvl_r <= rdSync_r[2];
      if (wrSync_r[1] == wrSync_r[2]) wrLvl_r <= wrSync_r[2];
      if (siSync_r[1] == siSync_r[2]) siLvl_r <= siSync_r[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register state
  reg [15:0] pc_r;
  reg [15:0] pc_nxt;
  reg [15:0] ptr_r [1:3];
  reg [15:0] ptrSel_nxt;
  reg [7:0] acc_r;
  reg [7:0] acc_nxt;
  reg [7:0] ext_r;
  reg [7:0] ext_nxt;
  reg [7:0] stat_r;
  reg [7:0] stat_nxt;
  reg [7:0] instr_r;
  reg [7:0] dataIo_r;
  reg [7:0] dataIo_nxt;
  reg serOut_r;
  reg serOut_nxt;
  reg ptrWe;
  reg [1:0] ptrIdx;
  reg [15:0] eaNxt;

  // Sense bits are not stored; they are spliced in live on every read
  wire [7:0] statView = {stat_r[7:6], sbLvl_r, saLvl_r, stat_r[3:0]}; // [RULE24]
  wire cyIn = stat_r[`CRF_ST_CY];
  wire [15:0] selPtr = (opPtrSel == 2'h0) ? pc_r : ptr_r[opPtrSel];

  assign fetchAddr = pc_r;
  assign instrCode = instr_r;
  assign serialOut = serOut_r;
  assign userOut = stat_r[`CRF_ST_F2:`CRF_ST_F0]; // [RULE17]
  assign busDataOut = dataIo_r; // [RULE9]
  assign busDataOe = ~wrLvl_r; // [RULE9]
  // Only the first sense input can request service, and only when gated
  assign irqRequest = stat_r[`CRF_ST_IE] & saLvl_r; // [RULE18] [RULE19] [RULE20]

  ////////////////////////////////////////////////////////////////////////
  // ALU: binary add, complement add and BCD add share the carry/link
  wire [7:0] addB = (opCode == `CRF_OP_CADD) ? ~dataIo_r : dataIo_r;
  wire [8:0] binSum = {1'b0, acc_r} + {1'b0, addB} + {8'h00, cyIn}; // [RULE22]
  wire binOv = (acc_r[7] == addB[7]) && (binSum[7] != acc_r[7]); // [RULE21]
  wire [4:0] loRaw = {1'b0, acc_r[3:0]} + {1'b0, dataIo_r[3:0]} + {4'h0, cyIn};
  wire loCy = (loRaw > 5'h09);
  wire [4:0] loAdj = loCy ? (loRaw + 5'h06) : loRaw;
  wire [4:0] hiRaw = {1'b0, acc_r[7:4]} + {1'b0, dataIo_r[7:4]} + {4'h0, loCy};
  wire hiCy = (hiRaw > 5'h09);
  wire [4:0] hiAdj = hiCy ? (hiRaw + 5'h06) : hiRaw;
  wire [7:0] bcdSum = {hiAdj[3:0], loAdj[3:0]}; // [RULE10]

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic for one microcycle operation
  always @* begin
    pc_nxt = pc_r;
    acc_nxt = acc_r;
    ext_nxt = ext_r;
    stat_nxt = stat_r;
    dataIo_nxt = dataIo_r;
    serOut_nxt = serOut_r;
    ptrWe = 1'b0;
    ptrIdx = opPtrSel;
    ptrSel_nxt = selPtr;
    eaNxt = effAddr;
    case (opCode)
      `CRF_OP_FETCH: begin
        pc_nxt = {pc_r[15:12], pc_r[11:0] + 12'h001}; // [RULE1] [RULE2]
      end
      `CRF_OP_BUSWR: begin
        dataIo_nxt = acc_r; // [RULE9]
      end
      `CRF_OP_OR: begin
        acc_nxt = acc_r | dataIo_r; // [RULE10]
      end
      `CRF_OP_XOR: begin
        acc_nxt = acc_r ^ dataIo_r; // [RULE10]
      end
      `CRF_OP_INC: begin
        dataIo_nxt = dataIo_r + 8'h01; // [RULE10]
        acc_nxt = dataIo_r + 8'h01;
      end
      `CRF_OP_DEC: begin
        dataIo_nxt = dataIo_r - 8'h01; // [RULE10]
        acc_nxt = dataIo_r - 8'h01;
      end
      `CRF_OP_ADD, `CRF_OP_CADD: begin
        acc_nxt = binSum[7:0]; // [RULE6] [RULE10]
        stat_nxt[`CRF_ST_CY] = binSum[8]; // [RULE22]
        stat_nxt[`CRF_ST_OV] = binOv; // [RULE21]
      end
      `CRF_OP_DADD: begin
        acc_nxt = bcdSum; // [RULE10]
        stat_nxt[`CRF_ST_CY] = hiCy; // [RULE22]
      end
      `CRF_OP_SR: begin
        acc_nxt = {1'b0, acc_r[7:1]}; // [RULE11]
      end
      `CRF_OP_SRL: begin
        acc_nxt = {cyIn, acc_r[7:1]}; // [RULE11] [RULE22]
      end
      `CRF_OP_SIO: begin
        ext_nxt = {siLvl_r, ext_r[7:1]}; // [RULE11]
        serOut_nxt = ext_r[0];
      end
      `CRF_OP_RR: begin
        acc_nxt = {acc_r[0], acc_r[7:1]}; // [RULE11]
      end
      `CRF_OP_RRL: begin
        acc_nxt = {cyIn, acc_r[7:1]}; // [RULE11] [RULE22]
        stat_nxt[`CRF_ST_CY] = acc_r[0];
      end
      `CRF_OP_XPL: begin
        if (opPtrSel != 2'h0) begin
          ptrWe = 1'b1;
          ptrSel_nxt = {selPtr[15:8], acc_r}; // [RULE12]
          acc_nxt = selPtr[7:0];
        end
      end
      `CRF_OP_XPH: begin
        if (opPtrSel != 2'h0) begin
          ptrWe = 1'b1;
          ptrSel_nxt = {acc_r, selPtr[7:0]}; // [RULE12]
          acc_nxt = selPtr[15:8];
        end
      end
      `CRF_OP_XPPC: begin
        if (opPtrSel != 2'h0) begin
          ptrWe = 1'b1;
          ptrSel_nxt = pc_r; // [RULE13]
          pc_nxt = selPtr; // [RULE3] [RULE13]
        end
      end
      `CRF_OP_IRQ: begin
        // Service entry swaps PC with pointer 3 and closes the gate
        if (irqRequest) begin
          ptrWe = 1'b1;
          ptrIdx = 2'h3;
          ptrSel_nxt = pc_r; // [RULE5]
          pc_nxt = ptr_r[3]; // [RULE5]
          stat_nxt[`CRF_ST_IE] = 1'b0;
        end
      end
      `CRF_OP_LDE: begin
        acc_nxt = ext_r; // [RULE14]
      end
      `CRF_OP_XAE: begin
        acc_nxt = ext_r; // [RULE14]
        ext_nxt = acc_r;
      end
      `CRF_OP_CSA: begin
        acc_nxt = statView; // [RULE15]
      end
      `CRF_OP_CAS: begin
        stat_nxt = {acc_r[7:6], stat_r[5:4], acc_r[3:0]}; // [RULE16] [RULE18]
      end
      `CRF_OP_EA: begin
        // Displacement 0x80 means take the extension register instead
        eaNxt = selPtr + {{8{(opData == `CRF_DISP_EXT) ? ext_r[7] : opData[7]}},
          ((opData == `CRF_DISP_EXT) ? ext_r : opData)}; // [RULE7]
      end
      `CRF_OP_LDAC: begin
        acc_nxt = opData; // [RULE6]
      end
      `CRF_OP_LDPTR: begin
        if (opPtrSel != 2'h0) begin
          ptrWe = 1'b1;
          ptrSel_nxt = {acc_r, dataIo_r}; // [RULE4]
        end
      end
      default: begin
        pc_nxt = pc_r;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Visible registers; the register port write takes priority over ops
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pc_r <= `CRF_RST_16; // [RULE3] [RULE23]
      acc_r <= `CRF_RST_8; // [RULE23]
      ext_r <= `CRF_RST_8;
      stat_r <= `CRF_RST_8;
      instr_r <= `CRF_RST_8;
      dataIo_r <= `CRF_RST_8;
      serOut_r <= 1'b0;
      effAddr <= `CRF_RST_16;
    end else begin
      pc_r <= pc_nxt;
      acc_r <= acc_nxt;
      ext_r <= ext_nxt;
      stat_r <= stat_nxt;
      serOut_r <= serOut_nxt;
      effAddr <= eaNxt;
      dataIo_r <= dataIo_nxt;
      if (opCode == `CRF_OP_FETCH) instr_r <= busIn2_r; // [RULE8]
      if ((opCode == `CRF_OP_BUSRD) && !rdLvl_r) dataIo_r <= busIn2_r; // [RULE9]
      if (regWr) begin
        case (regAddr)
          `CRF_ADDR_PC: pc_r <= regWrData;
          `CRF_ADDR_AC: acc_r <= regWrData[7:0];
          `CRF_ADDR_EXT: ext_r <= regWrData[7:0];
          `CRF_ADDR_STAT: stat_r <= {regWrData[7:6], 2'b00, regWrData[3:0]}; // [RULE16]
          default: ext_r <= ext_nxt;
        endcase
      end
    end
  end

  genvar gi;
  generate
    for (gi = 1; gi <= 3; gi = gi + 1) begin : gPtr
      always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          ptr_r[gi] <= `CRF_RST_16; // [RULE23]
        end else if (regWr && (regAddr == gi)) begin
          ptr_r[gi] <= regWrData; // [RULE4]
        end else if (ptrWe && (ptrIdx == gi)) begin
          ptr_r[gi] <= ptrSel_nxt;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Register port read, data valid the cycle after the strobe
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      regRdData <= 16'h0000;
    end else if (regRd) begin
      case (regAddr)
        `CRF_ADDR_PC: regRdData <= pc_r;
        `CRF_ADDR_P1: regRdData <= ptr_r[1];
        `CRF_ADDR_P2: regRdData <= ptr_r[2];
        `CRF_ADDR_P3: regRdData <= ptr_r[3];
        `CRF_ADDR_AC: regRdData <= {8'h00, acc_r};
        `CRF_ADDR_EXT: regRdData <= {8'h00, ext_r};
        `CRF_ADDR_STAT: regRdData <= {8'h00, statView}; // [RULE24]
        default: regRdData <= 16'h0000;
      endcase
    end else begin
      regRdData <= 16'h0000;
    end
  end
endmodule // crf_core

/* include/crf_consts.vh */
`ifndef CRF_CONSTS_VH
`define CRF_CONSTS_VH
// Operation codes on the opCode port
`define CRF_OP_NOP 5'h00
`define CRF_OP_FETCH 5'h01
`define CRF_OP_BUSRD 5'h02
`define CRF_OP_BUSWR 5'h03
`define CRF_OP_OR 5'h04
`define CRF_OP_XOR 5'h05
`define CRF_OP_INC 5'h06
`define CRF_OP_DEC 5'h07
`define CRF_OP_ADD 5'h08
`define CRF_OP_CADD 5'h09
`define CRF_OP_DADD 5'h0a
`define CRF_OP_SR 5'h0b
`define CRF_OP_SRL 5'h0c
`define CRF_OP_SIO 5'h0d
`define CRF_OP_RR 5'h0e
`define CRF_OP_RRL 5'h0f
`define CRF_OP_XPL 5'h10
`define CRF_OP_XPH 5'h11
`define CRF_OP_XPPC 5'h12
`define CRF_OP_LDE 5'h13
`define CRF_OP_XAE 5'h14
`define CRF_OP_CSA 5'h15
`define CRF_OP_CAS 5'h16
`define CRF_OP_EA 5'h17
`define CRF_OP_IRQ 5'h18
`define CRF_OP_LDAC 5'h19
`define CRF_OP_LDPTR 5'h1a
// Register port addresses
`define CRF_ADDR_PC 4'h0
`define CRF_ADDR_P1 4'h1
`define CRF_ADDR_P2 4'h2
`define CRF_ADDR_P3 4'h3
`define CRF_ADDR_AC 4'h4
`define CRF_ADDR_EXT 4'h5
`define CRF_ADDR_STAT 4'h6
// Status bit positions
`define CRF_ST_F0 0
`define CRF_ST_F2 2
`define CRF_ST_IE 3
`define CRF_ST_SA 4
`define CRF_ST_SB 5
`define CRF_ST_OV 6
`define CRF_ST_CY 7
// Reset values and constants
`define CRF_RST_16 16'h0000
`define CRF_RST_8 8'h00
`define CRF_DISP_EXT 8'h80
`define CRF_PC_LOW_W 12
`endif

/* verif/crf_core_monitor.sv */
`timescale 1ns/1ps
`include "crf_consts.vh"
module crf_core_monitor (
  input wire ref_clk,
  input wire resetn,
  input wire [4:0] opCode,
  input wire [7:0] busDataIn,
  input wire writeStrobeN,
  input wire irqSenseIn,
  input wire auxSenseIn,
  input wire [3:0] regAddr,
  input wire regWr,
  input wire regRd,
  input wire [15:0] regRdData,
  input wire busDataOe,
  input wire [15:0] effAddr,
  input wire [15:0] fetchAddr,
  input wire [7:0] instrCode,
  input wire [2:0] userOut,
  input wire irqRequest
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  wire pcWr = regWr && regAddr == `CRF_ADDR_PC;
  wire stWr = regWr && regAddr == `CRF_ADDR_STAT;
  wire stRd = regRd && regAddr == `CRF_ADDR_STAT;
  wire pcOp = opCode == `CRF_OP_FETCH || opCode == `CRF_OP_XPPC || opCode == `CRF_OP_IRQ;
  ////////////////////////////////////////////////////////////////
  property p_inc;
    opCode == `CRF_OP_FETCH && !pcWr |=>
      fetchAddr == {$past(fetchAddr[15:12]), $past(fetchAddr[11:0]) + 12'h001};
  endproperty
  a_inc: assert property (p_inc) else $error("pc step wrong");
  property p_pcHold;
    !pcOp && !pcWr |=> $stable(fetchAddr);
  endproperty
  a_pcHold: assert property (p_pcHold) else $error("pc moved");
  property p_rdPc;
    regRd && regAddr == `CRF_ADDR_PC |=> regRdData == $past(fetchAddr);
  endproperty
  a_rdPc: assert property (p_rdPc) else $error("pc read wrong");
  property p_flags;
    stRd |=> regRdData[2:0] == $past(userOut);
  endproperty
  a_flags: assert property (p_flags) else $error("flag pins differ");
  property p_flagHold;
    !stWr && opCode != `CRF_OP_CAS |=> $stable(userOut);
  endproperty
  a_flagHold: assert property (p_flagHold) else $error("flag pins moved");
  property p_irqOff;
    opCode == `CRF_OP_IRQ && !irqRequest && !pcWr |=> $stable(fetchAddr);
  endproperty
  a_irqOff: assert property (p_irqOff) else $error("gated irq taken");
  property p_irqClr;
    opCode == `CRF_OP_IRQ && irqRequest && !stWr |=> !irqRequest;
  endproperty
  a_irqClr: assert property (p_irqClr) else $error("irq gate kept");
  property p_senseA;
    (!irqSenseIn)[*6] |-> !irqRequest;
  endproperty
  a_senseA: assert property (p_senseA) else $error("irq without sense");
  property p_senseB;
    auxSenseIn[*6] ##0 stRd |=> regRdData[5];
  endproperty
  a_senseB: assert property (p_senseB) else $error("sense bit low");
  property p_oe;
    (!writeStrobeN)[*6] |-> busDataOe;
  endproperty
  a_oe: assert property (p_oe) else $error("bus not driven");
  property p_instr;
    $stable(busDataIn)[*4] ##0 opCode == `CRF_OP_FETCH |=> instrCode == $past(busDataIn);
  endproperty
  a_instr: assert property (p_instr) else $error("opcode not held");
  property p_eaHold;
    opCode != `CRF_OP_EA |=> $stable(effAddr);
  endproperty
  a_eaHold: assert property (p_eaHold) else $error("address moved");
  c_fetch: cover property (opCode == `CRF_OP_FETCH);
  c_irq: cover property (opCode == `CRF_OP_IRQ && irqRequest);
  c_sense: cover property (auxSenseIn[*6] ##0 stRd);
endmodule // crf_core_monitor
bind crf_core crf_core_monitor u_mon (.*);

/* verif/crf_core_tb.sv */
`timescale 1ns/1ps
`include "crf_consts.vh"
`define CHK(a, e) begin samplesChecked++; if ((a) !== (e)) begin numErrors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module crf_core_tb;
  reg ref_clk = 0;
  reg resetn = 0;
  reg [4:0] opCode = 0;
  reg [1:0] opPtrSel = 0;
  reg [7:0] opData = 0;
  reg [7:0] busDataIn = 0;
  reg readStrobeN = 1;
  reg writeStrobeN = 1;
  reg serialIn = 0;
  reg irqSenseIn = 0;
  reg auxSenseIn = 0;
  reg [3:0] regAddr = 0;
  reg [15:0] regWrData = 0;
  reg regWr = 0;
  reg regRd = 0;
  wire [15:0] regRdData, effAddr, fetchAddr;
  wire [7:0] busDataOut, instrCode;
  wire busDataOe, serialOut, irqRequest;
  wire [2:0] userOut;
  integer numErrors = 0;
  integer samplesChecked = 0;
  integer i;
  crf_core uut (.*);
  initial forever #4 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////
  task tick(input integer n);
    repeat (n) @(posedge ref_clk);
  endtask
  task wr(input [3:0] a, input [15:0] d);
    begin
      @(posedge ref_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge ref_clk);
      regWr <= 1'b0;
    end
  endtask
  task rd(input [3:0] a, input [15:0] e);
    begin
      @(posedge ref_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge ref_clk);
      regRd <= 1'b0;
      #1;
      `CHK(regRdData, e)
    end
  endtask
  task op(input [4:0] c, input [1:0] s);
    begin
      @(posedge ref_clk);
      opCode <= c;
      opPtrSel <= s;
      @(posedge ref_clk);
      opCode <= `CRF_OP_NOP;
      #1;
    end
  endtask
  // Status written first, so carry-in is always known
  task alu(input [7:0] st, input [7:0] a, input [4:0] c, input [7:0] ea, input [7:0] es);
    begin
      wr(4'h6, {8'h00, st});
      wr(4'h4, {8'h00, a});
      op(c, 2'h0);
      rd(4'h4, {8'h00, ea});
      rd(4'h6, {8'h00, es});
    end
  endtask
  task giveVerdict;
    begin
      $display("Mismatches %0d of %0d checks", numErrors, samplesChecked);
      if (numErrors == 0 && samplesChecked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    #400000;
    numErrors++;
    giveVerdict;
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    tick(3);
    resetn <= 1'b1;
    busDataIn <= 8'h5a;
    for (i = 0; i < 8; i++) rd(i[3:0], 16'h0000);
    wr(4'h0, 16'h1fff);
    op(`CRF_OP_FETCH, 2'h0);
    `CHK(fetchAddr, 16'h1000)
    `CHK(instrCode, 8'h5a)
    wr(4'h1, 16'h1234);
    rd(4'h1, 16'h1234);
    op(`CRF_OP_XPPC, 2'h1);
    `CHK(fetchAddr, 16'h1234)
    rd(4'h1, 16'h1000);
    wr(4'h2, 16'habcd);
    wr(4'h4, 16'h0011);
    op(`CRF_OP_XPL, 2'h2);
    rd(4'h2, 16'hab11);
    rd(4'h4, 16'h00cd);
    op(`CRF_OP_XPH, 2'h2);
    rd(4'h2, 16'hcd11);
    rd(4'h4, 16'h00ab);
    wr(4'h5, 16'h003c);
    op(`CRF_OP_LDE, 2'h0);
    rd(4'h4, 16'h003c);
    wr(4'h4, 16'h0077);
    op(`CRF_OP_XAE, 2'h0);
    rd(4'h4, 16'h003c);
    serialIn <= 1'b1;
    // Serial pin passes the three-stage synchroniser before the shift sees it
    tick(5);
    op(`CRF_OP_SIO, 2'h0);
    rd(4'h5, 16'h00bb);
    `CHK(serialOut, 1'b1)
    wr(4'h6, 16'h00f7);
    rd(4'h6, 16'h00c7);
    `CHK(userOut, 3'h7)
    op(`CRF_OP_CSA, 2'h0);
    rd(4'h4, 16'h00c7);
    rd(4'h6, 16'h00c7);
    wr(4'h4, 16'h0035);
    op(`CRF_OP_CAS, 2'h0);
    rd(4'h6, 16'h0005);
    rd(4'h4, 16'h0035);
    `CHK(userOut, 3'h5)
    auxSenseIn <= 1'b1;
    tick(6);
    rd(4'h6, 16'h0025);
    `CHK(irqRequest, 1'b0)
    auxSenseIn <= 1'b0;
    irqSenseIn <= 1'b1;
    tick(6);
    rd(4'h6, 16'h0015);
    `CHK(irqRequest, 1'b0)
    op(`CRF_OP_IRQ, 2'h0);
    `CHK(fetchAddr, 16'h1234)
    wr(4'h3, 16'h0fff);
    wr(4'h6, 16'h0008);
    #1;
    `CHK(irqRequest, 1'b1)
    op(`CRF_OP_IRQ, 2'h0);
    `CHK(fetchAddr, 16'h0fff)
    `CHK(irqRequest, 1'b0)
    rd(4'h3, 16'h1234);
    irqSenseIn <= 1'b0;
    busDataIn <= 8'h01;
    opData <= 8'h01;
    readStrobeN <= 1'b0;
    tick(6);
    op(`CRF_OP_BUSRD, 2'h0);
    readStrobeN <= 1'b1;
    wr(4'h4, 16'h0022);
    op(`CRF_OP_LDPTR, 2'h2);
    rd(4'h2, 16'h2201);
    alu(8'h00, 8'h80, `CRF_OP_OR, 8'h81, 8'h00);
    alu(8'h00, 8'h81, `CRF_OP_XOR, 8'h80, 8'h00);
    alu(8'h00, 8'h7f, `CRF_OP_ADD, 8'h80, 8'h40);
    alu(8'h00, 8'hff, `CRF_OP_ADD, 8'h00, 8'h80);
    alu(8'h80, 8'h10, `CRF_OP_ADD, 8'h12, 8'h00);
    alu(8'h80, 8'h05, `CRF_OP_CADD, 8'h04, 8'h80);
    alu(8'h40, 8'h99, `CRF_OP_DADD, 8'h00, 8'hc0);
    alu(8'h00, 8'h09, `CRF_OP_DADD, 8'h10, 8'h00);
    alu(8'h00, 8'h81, `CRF_OP_SR, 8'h40, 8'h00);
    alu(8'h80, 8'h81, `CRF_OP_SRL, 8'hc0, 8'h80);
    alu(8'h00, 8'h81, `CRF_OP_RR, 8'hc0, 8'h00);
    alu(8'h00, 8'h81, `CRF_OP_RRL, 8'h40, 8'h80);
    alu(8'h00, 8'h01, `CRF_OP_INC, 8'h02, 8'h00);
    alu(8'h00, 8'h02, `CRF_OP_DEC, 8'h01, 8'h00);
    wr(4'h5, 16'h0010);
    opData <= 8'h80;
    op(`CRF_OP_EA, 2'h1);
    `CHK(effAddr, 16'h1010)
    opData <= 8'hfe;
    op(`CRF_OP_EA, 2'h1);
    `CHK(effAddr, 16'h0ffe)
    opData <= 8'ha5;
    op(`CRF_OP_LDAC, 2'h0);
    rd(4'h4, 16'h00a5);
    op(`CRF_OP_BUSWR, 2'h0);
    writeStrobeN <= 1'b0;
    tick(6);
    `CHK(busDataOe, 1'b1)
    `CHK(busDataOut, 8'ha5)
    writeStrobeN <= 1'b1;
    tick(6);
    `CHK(busDataOe, 1'b0)
    resetn <= 1'b0;
    tick(2);
    resetn <= 1'b1;
    rd(4'h4, 16'h0000);
    `CHK(fetchAddr, 16'h0000)
    giveVerdict;
  end
endmodule // crf_core_tb
